// >>> rtl/overcurrent_retry_config.sv
// Banked overcurrent and auto-retry configuration registers with their decode.
// Assumes SPI words arrive deframed, one-cycle valid, on this clock; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - High range off forces low threshold level 1, low select ignored.
// - High range on gives level 2 or 3 by low select.
// - Current sensing is blocked while a protection window runs.
// - External clock divided by 512 or 256 per prescaler bit.
// - Clock source bit picks internal tick, else divided external clock.
// - Sense ratio bit one picks low-current ratio, zero high-current.
// - Low-current ratio scales all thresholds down by three.
// - Bulb runs high, middle, low slots; motor only high and low.
// - Bulb first window width from bit 4, second from bit 3.
// - Motor single window width from bits 4:3 four-way choice.
// - Upper threshold bit zero higher value, one lower value.
// - Middle threshold bit picks value; ignored for motor.
// - Offset polarity one adds offset current, zero subtracts.
// - Retry period bits choose one of four periods, default 00.
// - Unlimited bit with retry enabled removes the count limit.
// - Without unlimited bit retries stop after 16 attempts.
// - Retry count survives delatch and fault removal.
// - Bulb profile: retry bit one disables, zero enables retry.
// - Motor profile: retry bit one enables, zero disables retry.
// - Profile invert bit flips the load profile pin.
// - Register address sits in word bits 12 to 10 and is decoded.
// - Word bit 13 picks channel 0 or channel 1 bank.
module overcurrent_retry_config (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    // Deframed SPI word
    input wire logic [15:0] spi_word,
    input wire logic spi_word_valid,
    // Register readback
    input wire logic read_bank,
    input wire logic read_select,
    output logic [8:0] read_data,
    // Pins
    input wire logic [1:0] load_profile_pin,
    input wire logic ext_clock_pin,
    // Per-channel inputs
    input wire logic [1:0] internal_clock_tick,
    input wire logic [1:0] channel_on,
    input wire logic [1:0] retry_attempt,
    input wire logic [1:0] retry_clear,
    // Per-channel outputs
    output switch_cfg_pkg::chan_cfg_s [1:0] channel_cfg,
    output switch_cfg_pkg::slot_e [1:0] active_slot,
    output logic [1:0] sense_enable,
    output logic [1:0] pwm_tick,
    output logic [1:0] retry_allowed,
    output logic [1:0] retry_full
);
    import switch_cfg_pkg::*;

    logic [1:0][8:0] overcurrent_config;
    logic [1:0][8:0] auto_retry_config;
    logic [1:0] profile_meta;
    logic [1:0] profile_sync;
    logic [2:0] ext_sync;
    logic [2:0] ext_fill;
    logic ext_edge;
    logic [1:0][8:0] ext_count;
    logic [1:0] ext_div_tick;
    logic [1:0] motor;
    logic [1:0] window_active;
    win_cyc_t [1:0] first_cycles;
    win_cyc_t [1:0] second_cycles;
    logic write_bank;
    logic [2:0] write_addr;

    // Low threshold level from high range and low select
    function automatic logic [1:0] low_level_of(input logic [8:0] oc);
        if (!oc[HIGH_RANGE_BIT]) return 2'h1;
        return oc[LOW_THR_BIT] ? 2'h3 : 2'h2;
    endfunction : low_level_of

    // First window width for either profile
    function automatic win_cyc_t first_width(input logic [8:0] oc, input logic is_motor);
        logic [1:0] sel;
        sel = {oc[FIRST_WIN_BIT], oc[SECOND_WIN_BIT]};
        if (is_motor) begin
            unique case (sel)
                2'h0: return T_OCM1_M_CYC;
                2'h1: return T_OCM2_M_CYC;
                2'h2: return T_OCH1_CYC;
                2'h3: return T_OCH2_CYC;
            endcase
        end
        return oc[FIRST_WIN_BIT] ? T_OCH2_CYC : T_OCH1_CYC;
    endfunction : first_width

    // Address decode of the incoming word
    assign write_bank = spi_word[BANK_BIT];
    assign write_addr = spi_word[ADDR_MSB:ADDR_LSB];

    // Overcurrent registers, one per bank
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overcurrent_config <= {OVERCURRENT_RESET, OVERCURRENT_RESET};
        end else if (enable && spi_word_valid && write_addr == ADDR_OVERCURRENT) begin
            overcurrent_config[write_bank] <= spi_word[DATA_MSB:0];
        end
    end

    // Retry registers, one per bank
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            auto_retry_config <= {RETRY_RESET, RETRY_RESET};
        end else if (enable && spi_word_valid && write_addr == ADDR_RETRY) begin
            auto_retry_config[write_bank] <= spi_word[DATA_MSB:0];
        end
    end

    // Readback of the addressed bank
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            read_data <= '0;
        end else if (enable) begin
            read_data <= read_select ? auto_retry_config[read_bank] : overcurrent_config[read_bank];
        end
    end

    // Load profile pin synchroniser
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            profile_meta <= '0;
            profile_sync <= '0;
        end else if (enable) begin
            profile_meta <= load_profile_pin;
            profile_sync <= profile_meta;
        end
    end

    // External clock synchroniser and edge stage
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ext_sync <= '0;
        end else if (enable) begin
            ext_sync <= {ext_sync[1:0], ext_clock_pin};
        end
    end

    // Edge stage valid only once filled from the pin, so no false edge after reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ext_fill <= '0;
        end else if (enable) begin
            ext_fill <= {ext_fill[1:0], 1'b1};
        end
    end

    // Rising edge seen past the two synchroniser stages
    assign ext_edge = ext_sync[1] && !ext_sync[2] && ext_fill[2];

    // Per-channel combinational decode
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            motor[i] = profile_sync[i] ^ auto_retry_config[i][PROFILE_INV_BIT];
            first_cycles[i] = first_width(overcurrent_config[i], motor[i]);
            second_cycles[i] = overcurrent_config[i][SECOND_WIN_BIT] ? T_OCM2_L_CYC : T_OCM1_L_CYC;
            ext_div_tick[i] = ext_edge && (ext_count[i] == (overcurrent_config[i][PRESCALER_BIT]
                ? 9'(DIV_SLOW - 10'h001) : 9'(DIV_FAST - 10'h001)));
        end
    end

    // External clock dividers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ext_count <= '0;
        end else if (enable) begin
            for (int i = 0; i < 2; i++) begin
                if (ext_div_tick[i]) ext_count[i] <= '0;
                else if (ext_edge) ext_count[i] <= ext_count[i] + 9'h001;
            end
        end
    end

    // PWM clock source selection
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pwm_tick <= '0;
        end else if (enable) begin
            for (int i = 0; i < 2; i++) begin
                pwm_tick[i] <= overcurrent_config[i][CLOCK_INT_BIT] ? internal_clock_tick[i] : ext_div_tick[i];
            end
        end
    end

    // Registered decoded configuration
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            channel_cfg <= '0;
        end else if (enable) begin
            for (int i = 0; i < 2; i++) begin
                channel_cfg[i].low_level <= low_level_of(overcurrent_config[i]);
                channel_cfg[i].upper_low <= overcurrent_config[i][UPPER_THR_BIT];
                channel_cfg[i].middle_low <= overcurrent_config[i][MIDDLE_THR_BIT] && !motor[i];
                channel_cfg[i].ratio_low <= overcurrent_config[i][SENSE_RATIO_BIT];
                channel_cfg[i].scale_third <= overcurrent_config[i][SENSE_RATIO_BIT];
                channel_cfg[i].offset_add <= auto_retry_config[i][OFFSET_POL_BIT];
                channel_cfg[i].retry_period <= {auto_retry_config[i][PERIOD_HI_BIT],
                    auto_retry_config[i][PERIOD_LO_BIT]};
                channel_cfg[i].retry_enabled <= motor[i] ? auto_retry_config[i][RETRY_CTRL_BIT]
                    : !auto_retry_config[i][RETRY_CTRL_BIT];
                channel_cfg[i].retry_unlimited <= auto_retry_config[i][UNLIMITED_BIT];
                channel_cfg[i].motor <= motor[i];
            end
        end
    end

    // Sensing is gated off during protection windows
    assign sense_enable = ~window_active;

    // Per-channel slot sequencers and retry counters
    for (genvar g = 0; g < 2; g++) begin : g_chan
        window_sequencer u_seq (
            .clock(clock),
            .rst_n(rst_n),
            .enable(enable),
            .channel_on(channel_on[g]),
            .motor(motor[g]),
            .first_cycles(first_cycles[g]),
            .second_cycles(second_cycles[g]),
            .slot(active_slot[g]),
            .window_active(window_active[g])
        );
        retry_counter u_retry (
            .clock(clock),
            .rst_n(rst_n),
            .enable(enable),
            .retry_enabled(channel_cfg[g].retry_enabled),
            .unlimited(channel_cfg[g].retry_unlimited),
            .attempt(retry_attempt[g]),
            .clear(retry_clear[g]),
            .count(),
            .full(retry_full[g]),
            .allowed(retry_allowed[g])
        );
    end

    // Level 1 with high range off
    a_level_one: assert property (@(posedge clock) disable iff (!rst_n)
        enable && !overcurrent_config[0][HIGH_RANGE_BIT] |=> channel_cfg[0].low_level == 2'h1)
        else $error("level 1 not applied with high range off");

    // Level 2 or 3 with high range on
    a_level_two_three: assert property (@(posedge clock) disable iff (!rst_n)
        enable && overcurrent_config[1][HIGH_RANGE_BIT]
        |=> channel_cfg[1].low_level == ($past(overcurrent_config[1][LOW_THR_BIT]) ? 2'h3 : 2'h2))
        else $error("wrong low threshold level");

    // No sensing in high or middle slot
    a_sense_blocked: assert property (@(posedge clock) disable iff (!rst_n)
        active_slot[0] == SLOT_HIGH || active_slot[0] == SLOT_MIDDLE |-> !sense_enable[0])
        else $error("sensing active inside a window");

    // Divide by 256 wraps
    a_divider_wrap: assert property (@(posedge clock) disable iff (!rst_n)
        enable && ext_edge && !overcurrent_config[0][PRESCALER_BIT] && ext_count[0] == 9'h0ff
        |=> ext_count[0] == 9'h000)
        else $error("divide by 256 did not wrap");

    // Internal tick passed through
    a_internal_source: assert property (@(posedge clock) disable iff (!rst_n)
        enable && overcurrent_config[0][CLOCK_INT_BIT] |=> pwm_tick[0] == $past(internal_clock_tick[0]))
        else $error("internal clock not selected");

    // Motor retry bit taken as is
    a_motor_retry: assert property (@(posedge clock) disable iff (!rst_n)
        enable && motor[1] |=> channel_cfg[1].retry_enabled == $past(auto_retry_config[1][RETRY_CTRL_BIT]))
        else $error("motor retry enable inverted");

    // Bulb retry bit inverted
    a_bulb_retry: assert property (@(posedge clock) disable iff (!rst_n)
        enable && !motor[0] |=> channel_cfg[0].retry_enabled != $past(auto_retry_config[0][RETRY_CTRL_BIT]))
        else $error("bulb retry enable not inverted");

    // Middle select ignored for motor
    a_middle_ignored: assert property (@(posedge clock) disable iff (!rst_n)
        enable && motor[0] |=> !channel_cfg[0].middle_low)
        else $error("middle select used in motor profile");

    // Bank 1 write leaves bank 0
    a_bank_isolation: assert property (@(posedge clock) disable iff (!rst_n)
        spi_word_valid && spi_word[BANK_BIT] |=> overcurrent_config[0] == $past(overcurrent_config[0])
        && auto_retry_config[0] == $past(auto_retry_config[0]))
        else $error("bank 1 write changed bank 0");

    // Bank 0 write leaves bank 1
    a_bank_isolation_one: assert property (@(posedge clock) disable iff (!rst_n)
        spi_word_valid && !spi_word[BANK_BIT] |=> overcurrent_config[1] == $past(overcurrent_config[1])
        && auto_retry_config[1] == $past(auto_retry_config[1]))
        else $error("bank 0 write changed bank 1");

    // Decoded profile follows pin and invert bit
    a_profile_invert: assert property (@(posedge clock) disable iff (!rst_n)
        enable |=> channel_cfg[0].motor
        == ($past(profile_sync[0]) ^ $past(auto_retry_config[0][PROFILE_INV_BIT])))
        else $error("profile not following pin and invert bit");
endmodule : overcurrent_retry_config
`default_nettype wire

// >>> rtl/retry_counter.sv
// Counts auto-retry attempts of one channel and stops them at the limit.
// Assumes attempt and clear pulses come from protection logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module retry_counter (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    // Control
    input wire logic retry_enabled,
    input wire logic unlimited,
    input wire logic attempt,
    input wire logic clear,
    // Status
    output logic [4:0] count,
    output logic full,
    output logic allowed
);
    import switch_cfg_pkg::*;

    assign full = (count == RETRY_LIMIT);
    assign allowed = retry_enabled && (unlimited || !full);

    // Saturating counter; only an explicit clear empties it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= '0;
        end else if (enable) begin
            if (attempt && allowed) count <= clear ? 5'h01 : (full ? count : count + 5'h01);
            else if (clear) count <= '0;
        end
    end

    a_limit_stops: assert property (@(posedge clock) disable iff (!rst_n)
        !unlimited && count == RETRY_LIMIT |-> !allowed)
        else $error("retry allowed past the limit");
    a_count_kept: assert property (@(posedge clock) disable iff (!rst_n)
        !attempt && !clear |=> count == $past(count))
        else $error("retry count changed without attempt or clear");
endmodule : retry_counter
`default_nettype wire

// >>> rtl/switch_cfg_pkg.sv
// Shared constants and types for the per-channel overcurrent and retry configuration.
// Assumes a single 250 MHz clock domain and an upstream SPI deframer.
package switch_cfg_pkg;
    // Clock rate
    localparam int CLOCK_MHZ = 250;
    // SPI word fields
    localparam int BANK_BIT = 13;
    localparam int ADDR_MSB = 12;
    localparam int ADDR_LSB = 10;
    localparam int DATA_MSB = 8;
    localparam logic [2:0] ADDR_OVERCURRENT = 3'h4;
    localparam logic [2:0] ADDR_RETRY = 3'h5;
    // Overcurrent register fields
    localparam int HIGH_RANGE_BIT = 8;
    localparam int PRESCALER_BIT = 7;
    localparam int CLOCK_INT_BIT = 6;
    localparam int SENSE_RATIO_BIT = 5;
    localparam int FIRST_WIN_BIT = 4;
    localparam int SECOND_WIN_BIT = 3;
    localparam int UPPER_THR_BIT = 2;
    localparam int MIDDLE_THR_BIT = 1;
    localparam int LOW_THR_BIT = 0;
    // Retry register fields
    localparam int OFFSET_POL_BIT = 8;
    localparam int PROFILE_INV_BIT = 4;
    localparam int PERIOD_HI_BIT = 3;
    localparam int PERIOD_LO_BIT = 2;
    localparam int UNLIMITED_BIT = 1;
    localparam int RETRY_CTRL_BIT = 0;
    // Reset values
    localparam logic [8:0] OVERCURRENT_RESET = 9'h000;
    localparam logic [8:0] RETRY_RESET = 9'h000;
    // External clock dividers and retry limit
    localparam logic [9:0] DIV_SLOW = 10'h200;
    localparam logic [9:0] DIV_FAST = 10'h100;
    localparam logic [4:0] RETRY_LIMIT = 5'h10;
    // Window widths in ns and in cycles
    typedef logic [15:0] win_cyc_t;
    localparam int T_OCH1_NS = 1000;
    localparam int T_OCH2_NS = 2000;
    localparam int T_OCM1_L_NS = 3000;
    localparam int T_OCM2_L_NS = 4000;
    localparam int T_OCM1_M_NS = 5000;
    localparam int T_OCM2_M_NS = 6000;
    localparam win_cyc_t T_OCH1_CYC = win_cyc_t'(T_OCH1_NS * CLOCK_MHZ / 1000);
    localparam win_cyc_t T_OCH2_CYC = win_cyc_t'(T_OCH2_NS * CLOCK_MHZ / 1000);
    localparam win_cyc_t T_OCM1_L_CYC = win_cyc_t'(T_OCM1_L_NS * CLOCK_MHZ / 1000);
    localparam win_cyc_t T_OCM2_L_CYC = win_cyc_t'(T_OCM2_L_NS * CLOCK_MHZ / 1000);
    localparam win_cyc_t T_OCM1_M_CYC = win_cyc_t'(T_OCM1_M_NS * CLOCK_MHZ / 1000);
    localparam win_cyc_t T_OCM2_M_CYC = win_cyc_t'(T_OCM2_M_NS * CLOCK_MHZ / 1000);
    // Protection slot, Gray along idle-high-middle-low
    typedef enum logic [1:0] {
        SLOT_IDLE = 2'h0,
        SLOT_HIGH = 2'h1,
        SLOT_MIDDLE = 2'h3,
        SLOT_LOW = 2'h2
    } slot_e;
    // Decoded channel configuration
    typedef struct packed {
        logic [1:0] low_level;
        logic upper_low;
        logic middle_low;
        logic ratio_low;
        logic scale_third;
        logic offset_add;
        logic [1:0] retry_period;
        logic retry_enabled;
        logic retry_unlimited;
        logic motor;
    } chan_cfg_s;
endpackage : switch_cfg_pkg

// >>> rtl/window_sequencer.sv
// Steps one channel through its overcurrent threshold slots after turn-on.
// Assumes channel_on comes from logic on the same clock and widths are at least one cycle.
`timescale 1ns/1ps
`default_nettype none
module window_sequencer (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    // Control
    input wire logic channel_on,
    input wire logic motor,
    input wire switch_cfg_pkg::win_cyc_t first_cycles,
    input wire switch_cfg_pkg::win_cyc_t second_cycles,
    // Status
    output switch_cfg_pkg::slot_e slot,
    output logic window_active
);
    import switch_cfg_pkg::*;

    win_cyc_t count;
    slot_e next_slot;

    // Slot transitions
    always_comb begin
        next_slot = slot;
        unique case (slot)
            SLOT_IDLE: next_slot = SLOT_HIGH;
            SLOT_HIGH: if (count == first_cycles - 16'h0001) next_slot = motor ? SLOT_LOW : SLOT_MIDDLE;
            SLOT_MIDDLE: if (count == second_cycles - 16'h0001) next_slot = SLOT_LOW;
            SLOT_LOW: next_slot = SLOT_LOW;
        endcase
        if (!channel_on) next_slot = SLOT_IDLE;
    end

    // Slot register and width counter
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            slot <= SLOT_IDLE;
            count <= '0;
        end else if (enable) begin
            slot <= next_slot;
            count <= (next_slot != slot) ? 16'h0000 : count + 16'h0001;
        end
    end

    assign window_active = (slot == SLOT_HIGH) || (slot == SLOT_MIDDLE);

    a_first_width: assert property (@(posedge clock) disable iff (!rst_n)
        enable && channel_on && slot == SLOT_HIGH && count == first_cycles - 16'h0001
        |=> slot == ($past(motor) ? SLOT_LOW : SLOT_MIDDLE))
        else $error("high slot did not end at its width");
    a_motor_no_middle: assert property (@(posedge clock) disable iff (!rst_n)
        enable && motor && slot == SLOT_HIGH |=> slot != SLOT_MIDDLE)
        else $error("motor profile entered middle slot");
endmodule : window_sequencer
`default_nettype wire

// >>> test/spi_host_model.sv
// Host model: microcontroller that hands the block deframed SPI words.
// Assumes the block samples a word on the rising clock edge while valid is high.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Clock
    input wire logic clock,
    // Deframed word
    output logic [15:0] spi_word,
    output logic spi_word_valid
);
    import switch_cfg_pkg::*;
    // Idle after time zero
    initial begin
        spi_word = 16'h0000;
        spi_word_valid = 1'b0;
    end
    // One-cycle word, then the inverted word so stale data never looks valid
    task automatic send(input logic bank, input logic [2:0] addr, input logic [8:0] data);
        @(negedge clock);
        spi_word = {2'b00, bank, addr, 1'b0, data};
        spi_word_valid = 1'b1;
        @(negedge clock);
        spi_word = ~spi_word;
        spi_word_valid = 1'b0;
    endtask : send
endmodule : spi_host_model
`default_nettype wire

// >>> test/test_overcurrent_retry_config.sv
// Self-checking bench for the banked overcurrent and auto-retry configuration.
// Assumes the host model drives the SPI word port; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_overcurrent_retry_config;
    import switch_cfg_pkg::*;
    logic clock, rst_n, enable, read_bank, read_select, ext_clock_pin, spi_word_valid;
    logic [15:0] spi_word;
    logic [8:0] read_data;
    logic [1:0] load_profile_pin, internal_clock_tick, channel_on, retry_attempt, retry_clear;
    logic [1:0] sense_enable, pwm_tick, retry_allowed, retry_full;
    chan_cfg_s [1:0] channel_cfg;
    slot_e [1:0] active_slot;
    int fails, compares, n, m;
    logic [8:0] ovc_tab [8] = '{9'h000, 9'h001, 9'h100, 9'h101, 9'h1fe, 9'h026, 9'h0db, 9'h15a};
    logic [8:0] rty_tab [8] = '{9'h000, 9'h101, 9'h01c, 9'h10b, 9'h012, 9'h0ff, 9'h1e3, 9'h006};
    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Host and design
    spi_host_model u_host (.clock(clock), .spi_word(spi_word), .spi_word_valid(spi_word_valid));
    overcurrent_retry_config u_dut (.clock(clock), .rst_n(rst_n), .enable(enable), .spi_word(spi_word),
        .spi_word_valid(spi_word_valid), .read_bank(read_bank), .read_select(read_select),
        .read_data(read_data), .load_profile_pin(load_profile_pin), .ext_clock_pin(ext_clock_pin),
        .internal_clock_tick(internal_clock_tick), .channel_on(channel_on), .retry_attempt(retry_attempt),
        .retry_clear(retry_clear), .channel_cfg(channel_cfg), .active_slot(active_slot),
        .sense_enable(sense_enable), .pwm_tick(pwm_tick), .retry_allowed(retry_allowed),
        .retry_full(retry_full));
    // Verdict and end of run
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_cyc(input int k);
        repeat (k) @(negedge clock);
    endtask : wait_cyc
    task automatic do_reset;
        @(negedge clock);
        rst_n = 1'b0;
        wait_cyc(3);
        rst_n = 1'b1;
    endtask : do_reset
    task automatic check_reg(input logic bank, input logic sel, input logic [8:0] exp);
        @(negedge clock);
        read_bank = bank;
        read_select = sel;
        wait_cyc(2);
        check("read_data", exp, read_data);
    endtask : check_reg
    // Expected decode of one channel
    function automatic chan_cfg_s exp_cfg(input logic [8:0] ovc, input logic [8:0] rty, input logic pin);
        chan_cfg_s c;
        c.motor = pin ^ rty[PROFILE_INV_BIT];
        c.low_level = !ovc[HIGH_RANGE_BIT] ? 2'h1 : (ovc[LOW_THR_BIT] ? 2'h3 : 2'h2);
        c.upper_low = ovc[UPPER_THR_BIT];
        c.middle_low = c.motor ? 1'b0 : ovc[MIDDLE_THR_BIT];
        c.ratio_low = ovc[SENSE_RATIO_BIT];
        c.scale_third = ovc[SENSE_RATIO_BIT];
        c.offset_add = rty[OFFSET_POL_BIT];
        c.retry_period = rty[PERIOD_HI_BIT:PERIOD_LO_BIT];
        c.retry_enabled = c.motor ? rty[RETRY_CTRL_BIT] : !rty[RETRY_CTRL_BIT];
        c.retry_unlimited = rty[UNLIMITED_BIT];
        return c;
    endfunction : exp_cfg
    // Turn channel 0 on and time its slots
    task automatic run_window(input logic pin, input logic [8:0] ovc, input int first, input int second);
        load_profile_pin[0] = pin;
        u_host.send(1'b0, ADDR_OVERCURRENT, ovc);
        wait_cyc(6);
        channel_on[0] = 1'b1;
        wait_cyc(1);
        n = 0;
        m = 0;
        while (active_slot[0] === SLOT_HIGH && n < 4000) begin
            m += (sense_enable[0] !== 1'b0);
            n++;
            wait_cyc(1);
        end
        check("high slot cycles", first, n);
        n = 0;
        while (active_slot[0] === SLOT_MIDDLE && n < 4000) begin
            m += (sense_enable[0] !== 1'b0);
            n++;
            wait_cyc(1);
        end
        check("middle slot cycles", second, n);
        check("slot after window", SLOT_LOW, active_slot[0]);
        check("sense in window", 0, m);
        check("sense after window", 1, sense_enable[0]);
        channel_on[0] = 1'b0;
        wait_cyc(2);
    endtask : run_window
    // Count PWM ticks over 512 external rising edges and periodic internal ticks
    task automatic run_pwm(input logic [8:0] ovc, input int ticks);
        do_reset;
        u_host.send(1'b0, ADDR_OVERCURRENT, ovc);
        wait_cyc(4);
        n = 0;
        m = 0;
        for (int k = 0; k < 2060; k++) begin
            if (k < 2048) ext_clock_pin = k[1];
            internal_clock_tick[0] = (k % 8 == 0);
            wait_cyc(1);
            n += (pwm_tick[0] === 1'b1);
            m += (pwm_tick[1] === 1'b1);
        end
        internal_clock_tick[0] = 1'b0;
        check("pwm ticks", ticks, n);
        check("pwm ticks ch1", 512 / DIV_FAST, m);
    endtask : run_pwm
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        fails++;
        stop_test;
    end
    // Main sequence
    initial begin
        {rst_n, read_bank, read_select, ext_clock_pin} = 4'h0;
        enable = 1'b1;
        {load_profile_pin, internal_clock_tick, channel_on, retry_attempt, retry_clear} = 10'h000;
        wait_cyc(3);
        rst_n = 1'b1;
        wait_cyc(3);
        check_reg(1'b1, 1'b0, 9'h000);
        check("cfg0 reset", exp_cfg(9'h000, 9'h000, 1'b0), channel_cfg[0]);
        // Both banks with inverse data, plus an unmapped write
        for (int i = 0; i < 8; i++) begin
            load_profile_pin = {~i[2], i[1]};
            u_host.send(1'b0, ADDR_OVERCURRENT, ovc_tab[i]);
            u_host.send(1'b0, ADDR_RETRY, rty_tab[i]);
            u_host.send(1'b1, ADDR_OVERCURRENT, ~ovc_tab[i]);
            u_host.send(1'b1, ADDR_RETRY, ~rty_tab[i]);
            u_host.send(1'b0, 3'h3, 9'h1ff);
            wait_cyc(6);
            check("cfg0", exp_cfg(ovc_tab[i], rty_tab[i], i[1]), channel_cfg[0]);
            check("cfg1", exp_cfg(~ovc_tab[i], ~rty_tab[i], ~i[2]), channel_cfg[1]);
            check_reg(1'b0, 1'b0, ovc_tab[i]);
            check_reg(1'b1, 1'b1, ~rty_tab[i]);
        end
        run_window(1'b0, 9'h000, T_OCH1_CYC, T_OCM1_L_CYC);
        run_window(1'b0, 9'h018, T_OCH2_CYC, T_OCM2_L_CYC);
        run_window(1'b1, 9'h008, T_OCM2_M_CYC, 0);
        run_window(1'b1, 9'h010, T_OCH1_CYC, 0);
        load_profile_pin = 2'b00;
        run_pwm(9'h000, 512 / DIV_FAST);
        run_pwm(9'h080, 512 / DIV_SLOW);
        run_pwm(9'h040, 258);
        // Retry limit, unlimited mode, disable and clear
        do_reset;
        u_host.send(1'b0, ADDR_RETRY, 9'h000);
        wait_cyc(4);
        for (int k = 0; k < RETRY_LIMIT; k++) begin
            check("allowed below limit", 1, retry_allowed[0]);
            retry_attempt[0] = 1'b1;
            wait_cyc(1);
            retry_attempt[0] = 1'b0;
            wait_cyc(1);
        end
        check("full at limit", 1, retry_full[0]);
        check("allowed at limit", 0, retry_allowed[0]);
        u_host.send(1'b0, ADDR_RETRY, 9'h002);
        wait_cyc(4);
        check("allowed unlimited", 1, retry_allowed[0]);
        check("count kept", 1, retry_full[0]);
        u_host.send(1'b0, ADDR_RETRY, 9'h003);
        wait_cyc(4);
        check("allowed when disabled", 0, retry_allowed[0]);
        retry_clear[0] = 1'b1;
        wait_cyc(1);
        retry_clear[0] = 1'b0;
        wait_cyc(1);
        check("full after clear", 0, retry_full[0]);
        stop_test;
    end
endmodule : test_overcurrent_retry_config
`default_nettype wire
